// ===== hdl/framer_defs.vh
`ifndef FRAMER_DEFS_VH
`define FRAMER_DEFS_VH
// register byte offsets
`define REG_CTRL        8'h00
`define REG_HDR_CFG     8'h04
`define REG_STATUS      8'h08
`define REG_ERRMAP      8'h0C
`define REG_FRAMES      8'h10
// control register fields
`define CTRL_ENABLE     0
`define CTRL_MODE20     1
`define CTRL_MERGER     2
`define CTRL_KEEP_STAT  3
`define CTRL_FMT_LO     4
`define CTRL_FMT_HI     6
`define CTRL_VERS_LO    8
`define CTRL_VERS_HI    10
`define CTRL_RESET      32'h0000_0100
// header config fields
`define HCFG_NS1_LO     0
`define HCFG_NS1_HI     2
`define HCFG_NS2_LO     3
`define HCFG_NS2_HI     7
`define HCFG_MOD_LO     8
`define HCFG_MOD_HI     11
`define HCFG_CRATE_LO   12
`define HCFG_CRATE_HI   15
`define HCFG_SEQ_LO     16
`define HCFG_SEQ_HI     21
`define HCFG_RESET      32'h0000_0000
// format codes
`define FMT_NEUTRAL     3'h0
`define FMT_SUPPRESSED  3'h1
`define FMT_BITFIELD    3'h2
`define FMT_THRESHOLD   3'h3
// word identifiers for neutral data
`define WID_PAYLOAD     2'h0
`define WID_HDR_STD     4'hC
`define WID_STAT_STD    4'hD
`define WID_HDR_MERGER  4'hE
`define WID_STAT_MERGER 4'hF
// status flag positions within the sub-status word
`define SF_PARITY       0
`define SF_PROTOCOL     1
`define SF_MISMATCH     2
`define SF_OVERFLOW     3
`define SF_MODULE       4
`define SF_DOWN         5
`define SF_TIMEOUT      6
`define SF_WIDTH        7
// neutral data word flag positions
`define NW_PROTOCOL     20
`define NW_DOWN         21
`define NW_VALID        22
// link timeout
`define CLK_PERIOD_NS   50
`define TIMEOUT_NS      100000
`define TIMEOUT_CYC     (`TIMEOUT_NS / `CLK_PERIOD_NS)
`endif

// ===== hdl/readout_subblock_framer.v
`timescale 1ns/1ns
`include "framer_defs.vh"
// Behaviour
// RQ1: header always sent; sub-status dropped only when all its error flags are zero
// RQ2: header carries 3-bit primary slice count
// RQ3: header carries 5-bit secondary slice count, zero unless software sets it
// RQ4: header carries 4-bit module number and 4-bit crate number
// RQ5: header carries 6-bit sequence field
// RQ6: header carries 3-bit format code, 0 neutral through 3 thresholded
// RQ7: header carries 3-bit format version, reset value one
// RQ8: header and sub-status carry 4-bit word identifier in top bits
// RQ9: parity error sets parity flag and latches failing pin into error map
// RQ10: input protocol error sets protocol error flag
// RQ11: crossing mismatch sets flag and copies low six bits of input number
// RQ12: sub-status carries acquisition overflow flag
// RQ13: sub-status carries module-specific error flag
// RQ14: link ready inactive sets link-down flag
// RQ15: timer expiring before any data sets timeout flag
// RQ16: sub-status repeats module, crate and sequence of its header
// RQ17: neutral words pass undecoded, without parity check or suppression
// RQ18: 16-bit link words zero-extended to 20 bits; 20-bit words copied
// RQ19: neutral packet is header, one word per valid input word, sub-status
// RQ20: neutral format forces mismatch and parity flags to zero
// RQ21: software programs neutral word identifier choice per module type
// RQ22: each neutral word carries protocol error, link down, data valid flags
// RQ23: neutral identifiers 00 payload, 1100/1101 standard, 1110/1111 merger
// RQ24: every error flag is one for failure, zero for no error
// RQ25: fixed field placement, word identifier in most significant bits
// RQ26: neutral words hold 20-bit data low, three flags just above
module readout_subblock_framer #(
  parameter TIMEOUT_CYCLES = `TIMEOUT_CYC,
  parameter PIN_W          = 4
) (
  // clock and reset
  input  wire              hclk,
  input  wire              hresetn,
  // ahb-lite slave
  input  wire              hsel,
  input  wire [7:0]        haddr,
  input  wire [1:0]        htrans,
  input  wire              hwrite,
  input  wire [2:0]        hsize,
  input  wire [31:0]       hwdata,
  input  wire              hready,
  output reg               hreadyout_ff,
  output reg               hresp_ff,
  output reg  [31:0]       hrdata_ff,
  // input link
  input  wire              trigger,
  input  wire [19:0]       link_data,
  input  wire              input_data_valid_n,
  input  wire              link_ready,
  input  wire              link_protocol_error,
  input  wire              link_parity_error,
  input  wire [PIN_W-1:0]  link_parity_pin,
  input  wire              crossing_check,
  input  wire [11:0]       link_crossing,
  input  wire [11:0]       timing_crossing,
  input  wire              acq_overflow,
  input  wire              module_error,
  // readout output link
  output reg  [31:0]       out_data_ff,
  output reg               out_valid_ff,
  output reg               out_last_ff
);

  localparam ST_IDLE = 2'd0;
  localparam ST_WAIT = 2'd1;
  localparam ST_DATA = 2'd2;
  localparam ST_STAT = 2'd3;
  localparam [31:0] TMO_LAST = TIMEOUT_CYCLES - 1;

  // selects identifier for a sub-block header or sub-status word
  function [3:0] word_identifier;
    input merger;
    input is_status;
    begin
      if (merger)
        word_identifier = is_status ? `WID_STAT_MERGER : `WID_HDR_MERGER; // [RQ23]
      else
        word_identifier = is_status ? `WID_STAT_STD : `WID_HDR_STD; // [RQ23]
    end
  endfunction

  reg  [31:0]      ctrl_ff;
  reg  [31:0]      hcfg_ff;
  reg  [PIN_W-1:0] errmap_pin_ff;
  reg              errmap_valid_ff;
  reg  [15:0]      frames_ff;
  reg  [`SF_WIDTH-1:0] last_flags_ff;
  reg  [1:0]       state_ff;
  reg  [1:0]       nxt_state;
  reg  [31:0]      timer_ff;
  reg  [`SF_WIDTH-1:0] flags_ff;
  reg  [`SF_WIDTH-1:0] nxt_flags;
  reg  [5:0]       bcn_ff;
  reg  [5:0]       nxt_bcn;
  reg  [22:0]      word_ff;
  reg              wr_pend_ff;
  reg  [7:0]       wr_addr_ff;
  reg  [31:0]      rd_mux;
  reg  [31:0]      nxt_out;
  reg              nxt_valid;
  reg              nxt_last;

  wire        tick_data_valid        = ~input_data_valid_n;
  wire        enable     = ctrl_ff[`CTRL_ENABLE];
  wire        merger     = ctrl_ff[`CTRL_MERGER];
  wire [2:0]  fmt        = ctrl_ff[`CTRL_FMT_HI:`CTRL_FMT_LO];
  wire [2:0]  vers       = ctrl_ff[`CTRL_VERS_HI:`CTRL_VERS_LO];
  wire        neutral    = (fmt == `FMT_NEUTRAL);
  wire [2:0]  slice_count_primary   = hcfg_ff[`HCFG_NS1_HI:`HCFG_NS1_LO];
  wire [4:0]  slice_count_secondary = hcfg_ff[`HCFG_NS2_HI:`HCFG_NS2_LO];
  wire [3:0]  module_num = hcfg_ff[`HCFG_MOD_HI:`HCFG_MOD_LO];
  wire [3:0]  crate_num  = hcfg_ff[`HCFG_CRATE_HI:`HCFG_CRATE_LO];
  wire [5:0]  seq_num    = hcfg_ff[`HCFG_SEQ_HI:`HCFG_SEQ_LO];
  wire        addr_ok    = hsel & hready & htrans[1];
  // the first data tick is sampled while still waiting, so both states are watched
  wire        parity_hit = link_parity_error & ~neutral &
                           ((state_ff == ST_WAIT) | (state_ff == ST_DATA));
  wire        bcn_bad    = crossing_check & (link_crossing != timing_crossing);
  // 16-bit mode zero-extends; the upper four bits of the link are then ignored
  wire [19:0] link_word  = ctrl_ff[`CTRL_MODE20] ? link_data               // [RQ18]
                                                 : {4'h0, link_data[15:0]}; // [RQ18]

  // header layout: id, version, format, sequence, crate, module, slice counts
  wire [31:0] header_word = {word_identifier(merger, 1'b0), vers, fmt, seq_num, // [RQ8] [RQ25]
                             crate_num, module_num,                            // [RQ4]
                             slice_count_secondary, slice_count_primary};      // [RQ2] [RQ3]

  // register read decode
  always @* begin
    rd_mux = 32'h0000_0000;
    case (haddr)
      `REG_CTRL:    rd_mux = ctrl_ff;
      `REG_HDR_CFG: rd_mux = hcfg_ff;
      `REG_STATUS:  rd_mux = {22'h00_0000, state_ff, 1'b0, last_flags_ff};
      `REG_ERRMAP:  rd_mux = {errmap_valid_ff, {(31-PIN_W){1'b0}}, errmap_pin_ff};
      `REG_FRAMES:  rd_mux = {16'h0000, frames_ff};
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  // ahb-lite: zero wait states, always okay; unmapped reads give zero
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
      hrdata_ff    <= 32'h0000_0000;
      wr_pend_ff   <= 1'b0;
      wr_addr_ff   <= 8'h00;
    end else begin
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
      wr_pend_ff   <= addr_ok & hwrite;
      if (addr_ok) begin
        wr_addr_ff <= haddr;
      end
      if (addr_ok & ~hwrite) begin
        hrdata_ff <= rd_mux;
      end
    end
  end

  // software registers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff         <= `CTRL_RESET; // [RQ7]
      hcfg_ff         <= `HCFG_RESET; // [RQ3]
      errmap_pin_ff   <= {PIN_W{1'b0}};
      errmap_valid_ff <= 1'b0;
    end else begin
      if (wr_pend_ff && wr_addr_ff == `REG_CTRL) begin
        ctrl_ff <= hwdata; // [RQ21]
      end
      if (wr_pend_ff && wr_addr_ff == `REG_HDR_CFG) begin
        hcfg_ff <= hwdata;
      end
      // a new parity error wins over a clearing write in the same cycle
      if (parity_hit) begin
        errmap_pin_ff   <= link_parity_pin; // [RQ9]
        errmap_valid_ff <= 1'b1;            // [RQ24]
      end else if (wr_pend_ff && wr_addr_ff == `REG_ERRMAP) begin
        errmap_valid_ff <= 1'b0;
      end
    end
  end

  // framing sequence and error accumulation
  always @* begin
    nxt_state = state_ff;
    nxt_flags = flags_ff;
    nxt_bcn   = bcn_ff;
    nxt_out   = out_data_ff;
    nxt_valid = 1'b0;
    nxt_last  = 1'b0;
    if (state_ff == ST_WAIT || state_ff == ST_DATA) begin
      if (link_protocol_error) begin
        nxt_flags[`SF_PROTOCOL] = 1'b1; // [RQ10] [RQ24]
      end
      if (!link_ready) begin
        nxt_flags[`SF_DOWN] = 1'b1; // [RQ14]
      end
      if (acq_overflow) begin
        nxt_flags[`SF_OVERFLOW] = 1'b1; // [RQ12]
      end
      if (module_error) begin
        nxt_flags[`SF_MODULE] = 1'b1; // [RQ13]
      end
      // only the first mismatch is captured so the crossing field stays meaningful
      if (!neutral && bcn_bad && !flags_ff[`SF_MISMATCH]) begin
        nxt_flags[`SF_MISMATCH] = 1'b1;      // [RQ11] [RQ20]
        nxt_bcn = link_crossing[5:0];        // [RQ11]
      end
      if (parity_hit) begin
        nxt_flags[`SF_PARITY] = 1'b1; // [RQ9] [RQ20]
      end
    end
    case (state_ff)
      ST_IDLE: begin
        nxt_flags = {`SF_WIDTH{1'b0}};
        nxt_bcn   = 6'h00;
        if (enable && trigger) begin
          nxt_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (tick_data_valid) begin
          nxt_out   = header_word; // [RQ1] [RQ5] [RQ6] [RQ19]
          nxt_valid = 1'b1;
          nxt_state = ST_DATA;
        end else if (timer_ff == TMO_LAST) begin
          nxt_flags[`SF_TIMEOUT] = 1'b1; // [RQ15]
          nxt_out   = header_word;       // [RQ1]
          nxt_valid = 1'b1;
          nxt_state = ST_STAT;
        end
      end
      ST_DATA: begin
        // one output word per input word, no parsing or suppression
        nxt_out   = {`WID_PAYLOAD, 7'h00, word_ff}; // [RQ17] [RQ19] [RQ23] [RQ26]
        nxt_valid = 1'b1;
        if (!tick_data_valid) begin
          nxt_state = ST_STAT;
        end
      end
      ST_STAT: begin
        nxt_state = ST_IDLE;
        if ((flags_ff != {`SF_WIDTH{1'b0}}) || ctrl_ff[`CTRL_KEEP_STAT]) begin // [RQ1]
          nxt_out   = {word_identifier(merger, 1'b1), bcn_ff, seq_num,   // [RQ8] [RQ11]
                       crate_num, module_num, 1'b0, flags_ff};           // [RQ16] [RQ25]
          nxt_valid = 1'b1;
        end
        nxt_last = 1'b1;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff      <= ST_IDLE;
      timer_ff      <= 32'h0000_0000;
      flags_ff      <= {`SF_WIDTH{1'b0}};
      bcn_ff        <= 6'h00;
      word_ff       <= 23'h00_0000;
      last_flags_ff <= {`SF_WIDTH{1'b0}};
      frames_ff     <= 16'h0000;
      out_data_ff   <= 32'h0000_0000;
      out_valid_ff  <= 1'b0;
      out_last_ff   <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      flags_ff     <= nxt_flags;
      bcn_ff       <= nxt_bcn;
      out_data_ff  <= nxt_out;
      out_valid_ff <= nxt_valid;
      out_last_ff  <= nxt_last;
      // one-tick delay lets the header go out before the first data word
      word_ff <= {tick_data_valid, ~link_ready, link_protocol_error, link_word}; // [RQ22] [RQ26]
      if (state_ff == ST_WAIT) begin
        timer_ff <= timer_ff + 32'h0000_0001;
      end else begin
        timer_ff <= 32'h0000_0000;
      end
      if (state_ff == ST_STAT) begin
        last_flags_ff <= flags_ff;
        frames_ff     <= frames_ff + 16'h0001;
      end
    end
  end

endmodule

// ===== verification/framer_checker_assertions.sv
`timescale 1ns/1ns
module framer_checker (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus answer
  input wire logic        hreadyout_ff,
  input wire logic        hresp_ff,
  // output link
  input wire logic [31:0] out_data_ff,
  input wire logic        out_valid_ff,
  input wire logic        out_last_ff
);
  logic [16:0] hdr_ff;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_hdr;
    out_valid_ff && out_data_ff[31:30] == 2'b11 && !out_data_ff[28];
  endsequence
  sequence s_stat;
    out_valid_ff && out_last_ff && out_data_ff[31:30] == 2'b11 && out_data_ff[28];
  endsequence
  sequence s_data;
    out_valid_ff && out_data_ff[31:30] == 2'b00;
  endsequence

  // header fields kept so each status word is matched against its own header
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hdr_ff <= 17'h0;
    else if (out_valid_ff && out_data_ff[31:30] == 2'b11 && !out_data_ff[28])
      hdr_ff <= out_data_ff[24:8];
  end

  chk_header_first: assert property ($rose(out_valid_ff) |-> s_hdr)
    else $error("frame did not open with a header word");
  chk_last_status: assert property (out_last_ff && out_valid_ff |-> s_stat)
    else $error("closing word is not a status word");
  chk_last_idle: assert property (out_last_ff |=> !out_valid_ff && !out_last_ff)
    else $error("output continued after frame end");
  chk_data_pad: assert property (s_data |-> out_data_ff[29:23] == 7'h00)
    else $error("payload word padding not zero");
  chk_tick_valid: assert property (s_data |-> out_data_ff[22])
    else $error("payload word without data valid flag");
  chk_status_copy: assert property (s_stat |-> out_data_ff[21:8] == hdr_ff[13:0])
    else $error("status ids differ from header");
  chk_neutral_clean: assert property (s_stat and hdr_ff[16:14] == 3'h0
    |-> out_data_ff[2] == 1'b0 && out_data_ff[0] == 1'b0 && out_data_ff[27:22] == 6'h00)
    else $error("neutral status carries parity or crossing fault");
  chk_bus_okay: assert property (hreadyout_ff && !hresp_ff)
    else $error("bus slave stalled or answered an error");
endmodule

// ===== verification/link_source.sv
`timescale 1ns/1ns
module link_source (
  // clock
  input wire logic    hclk,
  // front-end link
  output logic [19:0] link_data,
  output logic        input_data_valid_n,
  output logic        link_ready,
  output logic        link_protocol_error,
  output logic        link_parity_error,
  output logic [3:0]  link_parity_pin,
  output logic        crossing_check,
  output logic [11:0] link_crossing,
  output logic [11:0] timing_crossing,
  output logic        acq_overflow,
  output logic        module_error
);
  int          cnt = 0;
  logic [19:0] nxt_word = 20'h0;
  logic [5:0]  errs = 6'h0;
  logic        on;

  assign on = cnt > 0;
  assign timing_crossing = 12'h3C0;

  // errs: down, module, overflow, crossing, parity, protocol; held for the whole burst
  task start(input int n, input logic [19:0] base, input logic [5:0] e);
    @(negedge hclk);
    nxt_word = base;
    errs = e;
    cnt = n;
  endtask

  initial begin
    link_data = 20'h0;
    input_data_valid_n = 1'b1;
  end

  always @(posedge hclk) begin
    if (on) begin
      input_data_valid_n <= 1'b0;
      link_data <= nxt_word;
      nxt_word <= nxt_word + 20'h1;
      cnt <= cnt - 1;
    end else begin
      input_data_valid_n <= 1'b1;
      // idle data keeps moving so a stale capture shows up as a wrong word
      link_data <= ~link_data;
    end
    link_ready <= !(on && errs[5]);
    module_error <= on && errs[4];
    acq_overflow <= on && errs[3];
    link_crossing <= (on && errs[2]) ? 12'hA95 : 12'h3C0;
    link_parity_error <= on && errs[1];
    link_parity_pin <= (on && errs[1]) ? 4'h9 : 4'h0;
    link_protocol_error <= on && errs[0];
    crossing_check <= on;
  end
endmodule

// ===== verification/tb_readout_subblock_framer.sv
`timescale 1ns/1ns
`include "framer_defs.vh"
module tb_readout_subblock_framer;
  localparam logic [31:0] CFG = 32'h002D_6BD5;
  logic        hclk, hresetn, hsel, hwrite, trigger, got_last;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, rd;
  logic [31:0] q[$];
  wire         hreadyout_ff, hresp_ff, out_valid_ff, out_last_ff;
  wire [31:0]  hrdata_ff, out_data_ff;
  wire [19:0]  link_data;
  wire [11:0]  link_crossing, timing_crossing;
  wire [3:0]   link_parity_pin;
  wire         dav_n, link_ready, proto_err, par_err, xing_chk, acq_ovf, mod_err;
  int          num_errors = 0;
  int          checked = 0;
  int          cycles = 0;

  readout_subblock_framer #(.TIMEOUT_CYCLES(20)) u_readout_subblock_framer (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout_ff),
    .hreadyout_ff(hreadyout_ff), .hresp_ff(hresp_ff), .hrdata_ff(hrdata_ff),
    .trigger(trigger), .link_data(link_data), .input_data_valid_n(dav_n),
    .link_ready(link_ready), .link_protocol_error(proto_err), .link_parity_error(par_err),
    .link_parity_pin(link_parity_pin), .crossing_check(xing_chk),
    .link_crossing(link_crossing), .timing_crossing(timing_crossing),
    .acq_overflow(acq_ovf), .module_error(mod_err), .out_data_ff(out_data_ff),
    .out_valid_ff(out_valid_ff), .out_last_ff(out_last_ff));

  link_source u_link_source (
    .hclk(hclk), .link_data(link_data), .input_data_valid_n(dav_n),
    .link_ready(link_ready), .link_protocol_error(proto_err), .link_parity_error(par_err),
    .link_parity_pin(link_parity_pin), .crossing_check(xing_chk),
    .link_crossing(link_crossing), .timing_crossing(timing_crossing),
    .acq_overflow(acq_ovf), .module_error(mod_err));

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // captured on the falling edge so the waiting task never races the push
  always @(negedge hclk) begin
    if (out_valid_ff === 1'b1) q.push_back(out_data_ff);
    if (out_last_ff === 1'b1) got_last = 1'b1;
  end

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      conclude();
    end
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task conclude();
    $display("comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'b010;
    @(posedge hclk);
    while (hreadyout_ff !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout_ff !== 1'b1) @(posedge hclk);
    rd = hrdata_ff;
  endtask

  task frame(input logic [2:0] f, input logic m20, input logic mrg, input int n,
             input logic [19:0] base, input logic [5:0] e);
    bus(1'b1, `REG_CTRL, 32'h101 | {25'h0, f, 4'h0} | {29'h0, mrg, m20, 1'b0});
    q.delete();
    got_last = 1'b0;
    @(posedge hclk);
    trigger <= 1'b1;
    @(posedge hclk);
    trigger <= 1'b0;
    if (n > 0) u_link_source.start(n, base, e);
    for (int i = 0; i < 300 && !got_last; i++) @(posedge hclk);
    check({31'h0, got_last}, 32'h1);
  endtask

  function logic [31:0] hdr(input logic [3:0] id, input logic [2:0] f);
    return {id, 3'h1, f, CFG[21:0]};
  endfunction

  function logic [31:0] stat(input logic [3:0] id, input logic [5:0] xing, input logic [6:0] fl);
    return {id, xing, CFG[21:8], 1'b0, fl};
  endfunction

  initial begin
    {hresetn, hsel, hwrite, trigger, got_last} = 5'h0;
    {haddr, htrans, hsize, hwdata} = 45'h0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, `REG_CTRL, 32'h0);
    check(rd, `CTRL_RESET);
    bus(1'b0, `REG_HDR_CFG, 32'h0);
    check(rd, `HCFG_RESET);
    bus(1'b1, 8'h14, 32'hFFFF_FFFF);
    bus(1'b0, 8'h14, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, `REG_HDR_CFG, CFG);
    // 16-bit neutral: top nibble dropped, clean frame loses its status word
    frame(`FMT_NEUTRAL, 1'b0, 1'b0, 3, 20'hF1234, 6'h00);
    check(32'(q.size()), 32'h4);
    check(q[0], hdr(`WID_HDR_STD, `FMT_NEUTRAL));
    for (int i = 1; i < 4; i++) check(q[i], {12'h004, 4'h0, 16'h1233 + i[15:0]});
    // 20-bit neutral merger frame with every fault except link down
    frame(`FMT_NEUTRAL, 1'b1, 1'b1, 2, 20'hABCDE, 6'h1F);
    check(32'(q.size()), 32'h4);
    check(q[0], hdr(`WID_HDR_MERGER, `FMT_NEUTRAL));
    for (int i = 1; i < 3; i++) check(q[i], {12'h005, 20'hABCDD + i[19:0]});
    check(q[3], stat(`WID_STAT_MERGER, 6'h00, 7'h1A));
    // thresholded frame: link down, parity and crossing faults all reported
    frame(`FMT_THRESHOLD, 1'b1, 1'b0, 1, 20'h5A5A5, 6'h26);
    check(q[0], hdr(`WID_HDR_STD, `FMT_THRESHOLD));
    check(q[1], {12'h006, 20'h5A5A5});
    check(q[2], stat(`WID_STAT_STD, 6'h15, 7'h25));
    bus(1'b0, `REG_ERRMAP, 32'h0);
    check(rd, 32'h8000_0009);
    // no data at all: header then a status carrying only the timeout flag
    for (int f = 1; f < 3; f++) begin
      frame(f[2:0], 1'b0, 1'b0, 0, 20'h0, 6'h00);
      check(q[0], hdr(`WID_HDR_STD, f[2:0]));
      check(q[1], stat(`WID_STAT_STD, 6'h00, 7'h40));
    end
    bus(1'b0, `REG_STATUS, 32'h0);
    check(rd, 32'h0000_0040);
    bus(1'b0, `REG_FRAMES, 32'h0);
    check(rd, 32'h0000_0005);
    conclude();
  end
endmodule

bind readout_subblock_framer framer_checker u_framer_checker (
  .hclk(hclk), .hresetn(hresetn), .hreadyout_ff(hreadyout_ff), .hresp_ff(hresp_ff),
  .out_data_ff(out_data_ff), .out_valid_ff(out_valid_ff), .out_last_ff(out_last_ff));
